//--- fbdiv_params.svh
`ifndef FBDIV_PARAMS_SVH
`define FBDIV_PARAMS_SVH
// ***************************************
// register indices and byte addresses
// ***************************************
`define IDX_FB_CTL      8'h16
`define IDX_STAT_SEL    8'h17
`define IDX_DIV_STATE   8'h18
`define ADDR_FB_CTL     8'h58
`define ADDR_STAT_SEL   8'h5C
`define ADDR_DIV_STATE  8'h60
// ***************************************
// reset values
// ***************************************
`define RST_FB_CTL      8'h00
`define RST_STAT_SEL    8'h00
// ***************************************
// field positions
// ***************************************
`define BIT_RESET_AB    5
`define BIT_RESET_ALL   4
`define BIT_BYPASS      3
// ***************************************
// status select codes and bus response codes
// ***************************************
`define SEL_GROUND      6'h00
`define SEL_FB_OUT      6'h01
`define SEL_REF_OUT     6'h02
`define SEL_SWALLOW     6'h03
`define SEL_PRESCALE    6'h04
`define SEL_PD_UP       6'h05
`define SEL_PD_DOWN     6'h06
`define SEL_MON_GROUND  6'h20
`define SEL_MON_FIRST_REFERENCE_CLOCK    6'h21
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

//--- fbdiv_pkg.sv
package fbdiv_pkg;
   typedef enum logic [2:0] {
      P_DIV1  = 3'h0,
      P_DIV2  = 3'h1,
      P_DM23  = 3'h2,
      P_DM45  = 3'h3,
      P_DM89  = 3'h4,
      P_DM1617 = 3'h5,
      P_DM3233 = 3'h6,
      P_DIV3  = 3'h7
   } prescale_code_t;

   typedef struct packed {
      logic [1:0]     spare;
      logic           reset_ab;
      logic           reset_all;
      logic           bypass;
      prescale_code_t prescale;
   } fb_ctl_t;

   typedef struct packed {
      logic [5:0] sel;
      logic [1:0] spare;
   } stat_sel_t;
endpackage : fbdiv_pkg

//--- pll_feedback_divider_status_select.sv
`timescale 1ns/10ps
`include "fbdiv_params.svh"
module pll_feedback_divider_status_select (
   input  wire logic                aclk,        // 100 MHz clock
   input  wire logic                aresetn,     // sync reset, low
   input  wire logic [7:0]          awaddr,      // write address
   input  wire logic                awvalid,     // write addr valid
   output logic                     awready,     // write addr ready
   input  wire logic [31:0]         wdata,       // write data
   input  wire logic [3:0]          wstrb,       // byte strobes
   input  wire logic                wvalid,      // write data valid
   output logic                     wready,      // write data ready
   output logic [1:0]               bresp,       // write response
   output logic                     bvalid,      // write resp valid
   input  wire logic                bready,      // write resp ready
   input  wire logic [7:0]          araddr,      // read address
   input  wire logic                arvalid,     // read addr valid
   output logic                     arready,     // read addr ready
   output logic [31:0]              rdata,       // read data
   output logic [1:0]               rresp,       // read response
   output logic                     rvalid,      // read data valid
   input  wire logic                rready,      // read data ready
   input  wire logic [5:0]          swallow_count, // A count
   input  wire logic [12:0]         b_count,     // B count
   input  wire logic [13:0]         r_count,     // reference divide
   input  wire logic                pd_up_pin,   // detector up
   input  wire logic                pd_down_pin, // detector down
   input  wire logic                first_reference_clock_pin,    // first ref clock
   input  wire logic                diff_ref_pin,// differential ref
   input  wire logic                diff_mode,   // differential select
   output fbdiv_pkg::fb_ctl_t       active_ctl,  // applied control
   output logic                     status_pin   // status output
);
   import fbdiv_pkg::*;

   // ***************************************
   // pin synchronisers
   // ***************************************
   logic [3:0] sync1;
   logic [3:0] sync2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {pd_up_pin, pd_down_pin, first_reference_clock_pin, diff_ref_pin};
         sync2 <= sync1;
      end
   end

   // ***************************************
   // bus slave
   // ***************************************
   fb_ctl_t    ctl;
   stat_sel_t  sel_reg;
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       do_write;
   logic       wr_hit;
   logic [31:0] next_rdata;
   logic       rd_hit;

   assign do_write = aw_held && w_held && !bvalid;
   assign wr_hit = (aw_addr == `ADDR_FB_CTL) || (aw_addr == `ADDR_STAT_SEL)
                   || (aw_addr == `ADDR_DIV_STATE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         awready <= 1'b0;
         aw_addr <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         awready <= 1'b0;
         aw_addr <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else begin
         awready <= !aw_held && !bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wready <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         wready <= 1'b0;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else begin
         wready <= !w_held && !bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl     <= fb_ctl_t'(`RST_FB_CTL);
         sel_reg <= stat_sel_t'(`RST_STAT_SEL);
      end else if (do_write && w_strb[0]) begin
         if (aw_addr == `ADDR_FB_CTL)
            ctl <= fb_ctl_t'(w_data[7:0]);
         if (aw_addr == `ADDR_STAT_SEL)
            sel_reg <= stat_sel_t'(w_data[7:0]);
      end
   end

   // ***************************************
   // divider core
   // ***************************************
   stat_sel_t  active_sel;
   logic [5:0] pre_cnt;
   logic [5:0] swallow_cnt;
   logic [12:0] b_cnt;
   logic [13:0] r_cnt;
   logic [5:0] base_mod;
   logic       dual;
   logic [5:0] period;
   logic       pre_tick;
   logic       b_last;
   logic       n_tick;
   logic       hold_all;
   logic       fb_out;
   logic       ref_out;
   logic       pre_out;
   logic       swallow_out;

   assign hold_all = active_ctl.reset_all || ctl.reset_all;

   always_comb begin
      dual = 1'b1;
      case (active_ctl.prescale)
         P_DIV1:   begin base_mod = 6'h01; dual = 1'b0; end
         P_DIV2:   begin base_mod = 6'h02; dual = 1'b0; end
         P_DIV3:   begin base_mod = 6'h03; dual = 1'b0; end
         P_DM23:   base_mod = 6'h02;
         P_DM45:   base_mod = 6'h04;
         P_DM89:   base_mod = 6'h08;
         P_DM1617: base_mod = 6'h10;
         P_DM3233: base_mod = 6'h20;
         default:  begin base_mod = 6'h01; dual = 1'b0; end
      endcase
   end

   // one extra count per prescaler cycle until A cycles are swallowed
   assign period = (dual && swallow_cnt != swallow_count)
                   ? base_mod + 6'h01 : base_mod;
   assign pre_tick = (pre_cnt >= period - 6'h01);
   // a zero B count is treated as one so the loop never stalls
   assign b_last = active_ctl.bypass || (b_cnt + 13'h0001 >= b_count);
   assign n_tick = pre_tick && b_last;

   always_ff @(posedge aclk) begin
      if (!aresetn || hold_all) begin
         pre_cnt <= 6'h00;
      end else if (pre_tick) begin
         pre_cnt <= 6'h00;
      end else begin
         pre_cnt <= pre_cnt + 6'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || hold_all) begin
         b_cnt       <= 13'h0000;
         swallow_cnt <= 6'h00;
      end else if (n_tick) begin
         b_cnt       <= 13'h0000;
         swallow_cnt <= 6'h00;
      end else if (pre_tick) begin
         b_cnt <= b_cnt + 13'h0001;
         if (dual && swallow_cnt != swallow_count)
            swallow_cnt <= swallow_cnt + 6'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || hold_all) begin
         r_cnt   <= 14'h0000;
         ref_out <= 1'b0;
      end else if (r_cnt + 14'h0001 >= r_count) begin
         r_cnt   <= 14'h0000;
         ref_out <= !ref_out;
      end else begin
         r_cnt <= r_cnt + 14'h0001;
      end
   end

   // outputs toggle so the status pin carries a divided clock
   always_ff @(posedge aclk) begin
      if (!aresetn || hold_all) begin
         fb_out      <= 1'b0;
         pre_out     <= 1'b0;
         swallow_out <= 1'b0;
      end else begin
         if (n_tick)
            fb_out <= !fb_out;
         if (pre_tick)
            pre_out <= !pre_out;
         if (pre_tick && dual && swallow_cnt + 6'h01 == swallow_count)
            swallow_out <= !swallow_out;
      end
   end

   // settings change on a feedback edge, or at once while reset_all is set, never otherwise mid-count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_ctl <= fb_ctl_t'(`RST_FB_CTL);
         active_sel <= stat_sel_t'(`RST_STAT_SEL);
      end else if (n_tick || hold_all) begin
         active_ctl <= ctl;
         active_sel <= sel_reg;
      end
   end

   // ***************************************
   // status pin mux
   // ***************************************
   logic next_status;
   always_comb begin
      case (active_sel.sel)
         `SEL_FB_OUT:     next_status = fb_out;
         `SEL_REF_OUT:    next_status = ref_out;
         `SEL_SWALLOW:    next_status = swallow_out;
         `SEL_PRESCALE:   next_status = pre_out;
         `SEL_PD_UP:      next_status = sync2[3];
         `SEL_PD_DOWN:    next_status = sync2[2];
         `SEL_MON_FIRST_REFERENCE_CLOCK:   next_status = diff_mode ? sync2[0] : sync2[1];
         `SEL_MON_GROUND: next_status = 1'b0;
         default:         next_status = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         status_pin <= 1'b0;
      else
         status_pin <= next_status;
   end

   // ***************************************
   // read channel
   // ***************************************
   always_comb begin
      rd_hit = 1'b1;
      case (araddr)
         `ADDR_FB_CTL:    next_rdata = {24'h0, ctl};
         `ADDR_STAT_SEL:  next_rdata = {24'h0, sel_reg};
         `ADDR_DIV_STATE: next_rdata = {20'h0, ref_out, fb_out,
                                        active_sel.sel, active_ctl.bypass,
                                        active_ctl.prescale};
         default: begin
            next_rdata = 32'h0;
            rd_hit     = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= next_rdata;
         rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else begin
         arready <= !rvalid;
      end
   end
endmodule : pll_feedback_divider_status_select

//--- fbdiv_asserts.sv
`timescale 1ns/10ps
`include "fbdiv_params.svh"
module fbdiv_asserts (
   input wire logic        aclk,       // clock
   input wire logic        aresetn,    // sync reset, low
   input wire logic        awvalid,    // aw valid
   input wire logic        awready,    // aw ready
   input wire logic        wvalid,     // w valid
   input wire logic        wready,     // w ready
   input wire logic        bvalid,     // b valid
   input wire logic        bready,     // b ready
   input wire logic        arvalid,    // ar valid
   input wire logic        arready,    // ar ready
   input wire logic        rvalid,     // r valid
   input wire logic        rready,     // r ready
   input wire logic [1:0]  rresp,      // r response
   input wire logic [31:0] rdata,      // r data
   input wire logic        status_pin  // status output
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic wrote;
   // nothing but ground may show before the first write address is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) wrote <= 1'b0;
      else if (awvalid && awready) wrote <= 1'b1;
   end
   a_b_holds: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
      else $error("write not answered");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_ar_quiet: assert property (rvalid |-> !arready)
      else $error("read address open during response");
   a_err_zero: assert property (rvalid && rresp == `RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read carries data");
   a_upper_zero: assert property (rvalid |-> rdata[31:12] == 20'h0)
      else $error("unused read bits set");
   a_ground_default: assert property (!wrote |-> !status_pin)
      else $error("status pin not grounded by default");
   c_write: cover property (bvalid && bready);
   c_read: cover property (rvalid && rready);
   c_error: cover property (rvalid && rresp == `RESP_SLVERR);
endmodule : fbdiv_asserts
bind pll_feedback_divider_status_select fbdiv_asserts u_fbdiv_asserts (.aclk, .aresetn,
   .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
   .rready, .rresp, .rdata, .status_pin);

//--- testbench.sv
`timescale 1ns/10ps
`include "fbdiv_params.svh"
module testbench;
   import fbdiv_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0, diff_mode = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic [5:0]  a_cnt = 6'h00;
   logic [12:0] b_cnt = 13'h0001;
   logic [13:0] r_cnt = 14'h0003;
   logic [4:0]  pins = 5'h00;
   wire         awready, wready, bvalid, arready, rvalid, status_pin;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   fb_ctl_t     active_ctl;
   int          bad_count = 0, checked = 0, cycles = 0;
   always #5 aclk = ~aclk;
   pll_feedback_divider_status_select u_pll_feedback_divider_status_select (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .swallow_count(a_cnt), .b_count(b_cnt), .r_count(r_cnt), .pd_up_pin(pins[1]),
      .pd_down_pin(pins[2]), .first_reference_clock_pin(pins[3]), .diff_ref_pin(pins[4]), .diff_mode,
      .active_ctl, .status_pin);
   // *****************
   // bus and compare helpers
   // *****************
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic axi_write(logic [7:0] addr, logic [7:0] data, logic [1:0] resp);
      @(posedge aclk);
      awaddr  <= addr;
      wdata   <= {24'h000000, data};
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      check("bresp", resp, bresp);
   endtask : axi_write
   task automatic axi_read(logic [7:0] addr, logic [31:0] exp, logic [1:0] resp);
      @(posedge aclk);
      araddr  <= addr;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      check("rdata", exp, rdata);
      check("rresp", resp, rresp);
   endtask : axi_read
   // *****************
   // scenarios
   // *****************
   task automatic test_regs;
      axi_write(8'h40, 8'hAA, `RESP_SLVERR);
      axi_read(8'h40, 32'h0, `RESP_SLVERR);
      // low byte lane off: the write is answered but nothing is stored
      wstrb <= 4'hE;
      axi_write(`ADDR_FB_CTL, 8'h55, `RESP_OKAY);
      wstrb <= 4'hF;
      axi_read(`ADDR_FB_CTL, 32'h0, `RESP_OKAY);
      axi_read(`ADDR_STAT_SEL, 32'h0, `RESP_OKAY);
      $display("test_regs done");
   endtask : test_regs
   task automatic test_codes;
      for (int c = 0; c < 8; c++) begin
         axi_write(`ADDR_FB_CTL, 8'h10 | c[7:0], `RESP_OKAY);
         axi_write(`ADDR_DIV_STATE, 8'hFF, `RESP_OKAY);
         axi_read(`ADDR_FB_CTL, {24'h0, 8'h10 | c[7:0]}, `RESP_OKAY);
         axi_read(`ADDR_DIV_STATE, {29'h0, c[2:0]}, `RESP_OKAY);
         check("active_ctl", {24'h0, 8'h10 | c[7:0]}, active_ctl);
      end
      $display("test_codes done");
   endtask : test_codes
   // target pin follows v, all others the inverse
   task automatic sel_case(logic [5:0] code, int which, logic dm);
      diff_mode <= dm;
      axi_write(`ADDR_STAT_SEL, {code, 2'b00}, `RESP_OKAY);
      for (int v = 0; v < 2; v++) begin
         pins <= (v ? 5'h00 : 5'h1F) ^ (5'h01 << which);
         repeat (6) @(posedge aclk);
         check("status_pin", (which == 0) ? 0 : v, status_pin);
      end
   endtask : sel_case
   task automatic test_status;
      sel_case(`SEL_PD_UP, 1, 1'h0);
      sel_case(`SEL_PD_DOWN, 2, 1'h0);
      sel_case(`SEL_MON_FIRST_REFERENCE_CLOCK, 3, 1'h0);
      sel_case(`SEL_MON_FIRST_REFERENCE_CLOCK, 4, 1'h1);
      sel_case(`SEL_MON_GROUND, 0, 1'h0);
      sel_case(`SEL_GROUND, 0, 1'h0);
      sel_case(6'h07, 0, 1'h0);
      sel_case(6'h1F, 0, 1'h0);
      $display("test_status done");
   endtask : test_status
   task automatic div_case(logic [7:0] ctl, logic [5:0] a, logic [12:0] b, logic [5:0] sel,
                           int half);
      int   n;
      logic s;
      a_cnt <= a;
      b_cnt <= b;
      axi_write(`ADDR_FB_CTL, ctl | 8'h10, `RESP_OKAY);
      axi_write(`ADDR_STAT_SEL, {sel, 2'b00}, `RESP_OKAY);
      repeat (80) @(posedge aclk);
      s = status_pin;
      // counters held: the source must not move
      repeat (40) begin
         @(posedge aclk);
         check("held status", s, status_pin);
      end
      axi_write(`ADDR_FB_CTL, ctl, `RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         s = status_pin;
         do begin
            @(posedge aclk);
            n++;
         end while (status_pin === s && n < 200);
      end
      check("half period", half, n);
   endtask : div_case
   task automatic test_divide;
      div_case(8'h08, 6'h00, 13'h0005, `SEL_FB_OUT, 1);
      div_case(8'h09, 6'h00, 13'h0005, `SEL_FB_OUT, 2);
      div_case(8'h0F, 6'h00, 13'h0005, `SEL_FB_OUT, 3);
      div_case(8'h02, 6'h00, 13'h0002, `SEL_FB_OUT, 4);
      div_case(8'h02, 6'h01, 13'h0002, `SEL_FB_OUT, 5);
      div_case(8'h03, 6'h00, 13'h0001, `SEL_FB_OUT, 4);
      div_case(8'h03, 6'h01, 13'h0002, `SEL_FB_OUT, 9);
      div_case(8'h04, 6'h00, 13'h0001, `SEL_FB_OUT, 8);
      div_case(8'h05, 6'h00, 13'h0001, `SEL_FB_OUT, 16);
      div_case(8'h06, 6'h00, 13'h0001, `SEL_FB_OUT, 32);
      div_case(8'h06, 6'h01, 13'h0001, `SEL_FB_OUT, 33);
      div_case(8'h01, 6'h00, 13'h0005, `SEL_PRESCALE, 2);
      div_case(8'h02, 6'h01, 13'h0002, `SEL_SWALLOW, 5);
      div_case(8'h00, 6'h00, 13'h0001, `SEL_REF_OUT, 3);
      $display("test_divide done");
   endtask : test_divide
   // a new setting waits for the next feedback edge, 32 cycles apart here
   task automatic test_apply;
      logic s;
      axi_write(`ADDR_STAT_SEL, {`SEL_FB_OUT, 2'b00}, `RESP_OKAY);
      axi_write(`ADDR_FB_CTL, 8'h06, `RESP_OKAY);
      repeat (40) @(posedge aclk);
      s = status_pin;
      while (status_pin === s) @(posedge aclk);
      axi_write(`ADDR_FB_CTL, 8'h00, `RESP_OKAY);
      check("pending setting", 32'h06, active_ctl);
      repeat (40) @(posedge aclk);
      check("applied setting", 32'h00, active_ctl);
      $display("test_apply done");
   endtask : test_apply
   task automatic conclude;
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   // run needs a few thousand cycles; ceiling leaves ample margin
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      test_regs();
      test_codes();
      test_status();
      test_divide();
      test_apply();
      conclude();
   end
endmodule : testbench
